// file: core/codec_ctl_pkg.sv
// Package: register map, field layout and reset values of the codec control bank
package codec_ctl_pkg;
    localparam logic [7:0] TRANSDUCER_ADDR = 8'h0A;
    localparam logic [7:0] RX_GAIN_ADDR = 8'h0B;
    localparam logic [7:0] TRANSDUCER_RESET = 8'h00;
    localparam logic [7:0] RX_GAIN_RESET = 8'h00;
    // Receive gain register fields
    localparam int HIGHPASS_BIT = 7;
    localparam int FILTER_GAIN_MSB = 6;
    localparam int FILTER_GAIN_LSB = 4;
    localparam int DIGITAL_GAIN_MSB = 3;
    localparam int DIGITAL_GAIN_LSB = 0;
    // Transducer register fields
    localparam int DIAL_LOWPASS_BIT = 5;
    localparam int SIDETONE_BIT = 4;
    localparam int HS_MIC_BIT = 3;
    localparam int SP_MIC_BIT = 2;
    localparam int SP_SPKR_BIT = 1;
    localparam int HS_SPKR_BIT = 0;
    localparam logic [7:0] TRANSDUCER_USED_MASK = 8'h3F;
    // Synchroniser depth for the asynchronous bus strobes
    localparam int SYNC_STAGES = 2;
endpackage

// file: core/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous input levels
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Cleared to the pins' idle levels so release shows no edge
            meta_q <= RESET_VALUE;
            sync_q <= RESET_VALUE;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule
`default_nettype wire

// file: core/codec_gain_transducer_control.sv
// Codec receive gain and transducer control registers on the muxed bus
// Summary of operation
// [RL1] Bit 7 enables transmit highpass, notch shift
// [RL2] Host sets highpass for speakerphone mode
// [RL3] Bits 6-4 give filter gain, 1 dB
// [RL4] Bits 3-0 give digital gain, 6 dB
// [RL5] Receive gain register at 0BH, read/write
// [RL6] Transducer register at 0AH, read/write
// [RL7] Host writes zeros to bits 7,6
// [RL8] Bit 5 enables 1 kHz receive lowpass
// [RL9] Bit 4 switches sidetone on/off
// [RL10] Bit 3 powers handset microphone
// [RL11] Bit 2 powers speakerphone microphone
// [RL12] Bit 1 powers speakerphone speaker
// [RL13] Bit 0 powers handset speaker
// [RL14] Reset clears receive gain to zero
// [RL15] Digital gain applies regardless of DSP run
// [RL16] Filter gain codes span 0 to -7 dB
// [RL17] Digital gain codes span +42 to -42 dB
// [RL18] Reads return last written or reset value
`timescale 1ns/10ps
`default_nettype none
module codec_gain_transducer_control (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic cs_n_i,
    input wire logic addr_strobe_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [7:0] ad_i,
    output logic [7:0] ad_o,
    output logic ad_oe_o,
    output logic tx_highpass_enable_o,
    output logic [2:0] rx_filter_gain_o,
    output logic [3:0] rx_digital_gain_o,
    output logic dial_lowpass_enable_o,
    output logic sidetone_enable_o,
    output logic handset_mic_power_o,
    output logic speakerphone_mic_power_o,
    output logic speakerphone_speaker_power_o,
    output logic handset_speaker_power_o
);
    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Strobes and data pass two flops; the bus holds AD steady around
    // strobe edges, so a sampled bus value is stable when used.
    logic [11:0] pins_raw;
    logic [11:0] pins_s;
    logic cs_n_s;
    logic as_s;
    logic rd_n_s;
    logic wr_n_s;
    logic [7:0] ad_s;

    // Idle levels: strobes and select high, address strobe low. The
    // synchroniser clears to them, so no false strobe edge follows reset.
    localparam logic [11:0] IDLE_PINS = 12'hB00;

    assign pins_raw = {cs_n_i, addr_strobe_i, rd_n_i, wr_n_i, ad_i};

    pin_sync #(.WIDTH(12), .RESET_VALUE(IDLE_PINS)) u_pin_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .async_i(pins_raw),
        .sync_o(pins_s)
    );
    assign {cs_n_s, as_s, rd_n_s, wr_n_s, ad_s} = pins_s;

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
        is_reg = (a == r);
    endfunction

    // ------------------------------------------------------------
    // Bus cycle tracking
    // ------------------------------------------------------------
    logic as_q;
    logic as_d;
    logic wr_n_q;
    logic wr_n_d;
    logic [7:0] addr_q;
    logic [7:0] addr_d;
    logic as_fall;
    logic wr_rise;

    // Address latched on the falling edge of the address strobe
    assign as_fall = as_q && !as_s;
    // Data taken at the end of the write strobe, when it is settled
    assign wr_rise = !wr_n_q && wr_n_s && !cs_n_s;

    always_comb begin
        as_d = as_s;
        wr_n_d = wr_n_s;
        addr_d = as_fall ? ad_s : addr_q;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            as_q <= 1'b0;
            wr_n_q <= 1'b1;
            addr_q <= 8'h00;
        end else begin
            as_q <= as_d;
            wr_n_q <= wr_n_d;
            addr_q <= addr_d;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] rx_gain_q;
    logic [7:0] rx_gain_d;
    logic [7:0] xdcr_q;
    logic [7:0] xdcr_d;
    logic wr_gain;
    logic wr_xdcr;

    assign wr_gain = wr_rise &&
        is_reg(addr_q, codec_ctl_pkg::RX_GAIN_ADDR); // RL5
    assign wr_xdcr = wr_rise &&
        is_reg(addr_q, codec_ctl_pkg::TRANSDUCER_ADDR); // RL6

    always_comb begin
        rx_gain_d = rx_gain_q;
        xdcr_d = xdcr_q;
        if (wr_gain) begin
            rx_gain_d = ad_s; // RL5
        end
        if (wr_xdcr) begin
            // Unused upper bits are kept at zero even if host misbehaves
            xdcr_d = ad_s & codec_ctl_pkg::TRANSDUCER_USED_MASK; // RL7
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_gain_q <= codec_ctl_pkg::RX_GAIN_RESET; // RL14
            xdcr_q <= codec_ctl_pkg::TRANSDUCER_RESET;
        end else begin
            rx_gain_q <= rx_gain_d;
            xdcr_q <= xdcr_d;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic oe_q;
    logic oe_d;
    logic hit;

    assign hit = is_reg(addr_q, codec_ctl_pkg::RX_GAIN_ADDR) ||
        is_reg(addr_q, codec_ctl_pkg::TRANSDUCER_ADDR);

    always_comb begin
        // Only decoded addresses drive AD; other devices may share the bus
        oe_d = !cs_n_s && !rd_n_s && hit;
        rdata_d = 8'h00;
        if (is_reg(addr_q, codec_ctl_pkg::RX_GAIN_ADDR)) begin
            rdata_d = rx_gain_q; // RL18
        end else if (is_reg(addr_q, codec_ctl_pkg::TRANSDUCER_ADDR)) begin
            rdata_d = xdcr_q; // RL18
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
            oe_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            oe_q <= oe_d;
        end
    end

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    // Digital gain code leaves unconditionally: it stays in force even
    // while the DSP is halted, so no run-enable term gates it.
    assign tx_highpass_enable_o =
        rx_gain_q[codec_ctl_pkg::HIGHPASS_BIT]; // RL1
    assign rx_filter_gain_o = rx_gain_q[codec_ctl_pkg::FILTER_GAIN_MSB:
        codec_ctl_pkg::FILTER_GAIN_LSB]; // RL3 RL16
    assign rx_digital_gain_o = rx_gain_q[codec_ctl_pkg::DIGITAL_GAIN_MSB:
        codec_ctl_pkg::DIGITAL_GAIN_LSB]; // RL4 RL15 RL17
    assign dial_lowpass_enable_o =
        xdcr_q[codec_ctl_pkg::DIAL_LOWPASS_BIT]; // RL8
    assign sidetone_enable_o = xdcr_q[codec_ctl_pkg::SIDETONE_BIT]; // RL9
    assign handset_mic_power_o = xdcr_q[codec_ctl_pkg::HS_MIC_BIT]; // RL10
    assign speakerphone_mic_power_o =
        xdcr_q[codec_ctl_pkg::SP_MIC_BIT]; // RL11
    assign speakerphone_speaker_power_o =
        xdcr_q[codec_ctl_pkg::SP_SPKR_BIT]; // RL12
    assign handset_speaker_power_o =
        xdcr_q[codec_ctl_pkg::HS_SPKR_BIT]; // RL13
    assign ad_o = rdata_q;
    assign ad_oe_o = oe_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Bus-side terms use the synced strobes, the same copies the logic uses
    gain_write_lands_a: assert property ( // RL5
        @(posedge clk_i) disable iff (!rst_n)
        wr_gain |=> rx_gain_q == $past(ad_s))
        else $error("receive gain write not stored");
    xdcr_write_lands_a: assert property ( // RL6
        @(posedge clk_i) disable iff (!rst_n)
        wr_xdcr |=> xdcr_q ==
        ($past(ad_s) & codec_ctl_pkg::TRANSDUCER_USED_MASK))
        else $error("transducer write not stored");
    xdcr_top_zero_a: assert property ( // RL7
        @(posedge clk_i) disable iff (!rst_n)
        xdcr_q[7:6] == 2'h0)
        else $error("transducer unused bits set");
    addr_latch_a: assert property ( // RL5
        @(posedge clk_i) disable iff (!rst_n)
        as_fall |=> addr_q == $past(ad_s))
        else $error("bus address not latched");
    highpass_follow_a: assert property ( // RL1
        @(posedge clk_i) disable iff (!rst_n)
        wr_gain |=> tx_highpass_enable_o == $past(ad_s[7]))
        else $error("highpass enable mismatch");
    filter_gain_a: assert property ( // RL3
        @(posedge clk_i) disable iff (!rst_n)
        wr_gain |=> rx_filter_gain_o == $past(ad_s[6:4]))
        else $error("filter gain field mismatch");
    digital_gain_a: assert property ( // RL4
        @(posedge clk_i) disable iff (!rst_n)
        wr_gain |=> rx_digital_gain_o == $past(ad_s[3:0]))
        else $error("digital gain field mismatch");
    power_bits_a: assert property ( // RL8 RL9 RL10 RL11 RL12 RL13
        @(posedge clk_i) disable iff (!rst_n)
        wr_xdcr |=> {dial_lowpass_enable_o, sidetone_enable_o,
        handset_mic_power_o, speakerphone_mic_power_o,
        speakerphone_speaker_power_o, handset_speaker_power_o}
        == $past(ad_s[5:0]))
        else $error("transducer controls mismatch");
    gain_hold_a: assert property ( // RL18
        @(posedge clk_i) disable iff (!rst_n)
        !wr_gain |=> $stable(rx_gain_q))
        else $error("receive gain changed without write");
    xdcr_hold_a: assert property ( // RL18
        @(posedge clk_i) disable iff (!rst_n)
        !wr_xdcr |=> $stable(xdcr_q))
        else $error("transducer changed without write");
    // Read answers land one edge after the synced request
    read_data_a: assert property ( // RL18
        @(posedge clk_i) disable iff (!rst_n)
        (!cs_n_s && !rd_n_s &&
        is_reg(addr_q, codec_ctl_pkg::RX_GAIN_ADDR)) |=>
        ad_oe_o && ad_o == $past(rx_gain_q))
        else $error("read of receive gain wrong");
    xdcr_read_a: assert property ( // RL18
        @(posedge clk_i) disable iff (!rst_n)
        (!cs_n_s && !rd_n_s &&
        is_reg(addr_q, codec_ctl_pkg::TRANSDUCER_ADDR)) |=>
        ad_oe_o && ad_o == $past(xdcr_q))
        else $error("read of transducer wrong");
    unmapped_quiet_a: assert property ( // RL5 RL6
        @(posedge clk_i) disable iff (!rst_n)
        !hit |=> !ad_oe_o)
        else $error("unmapped address drove the bus");
    read_release_a: assert property ( // RL18
        @(posedge clk_i) disable iff (!rst_n)
        rd_n_s |=> !ad_oe_o)
        else $error("bus still driven after read");
    reset_zero_a: assert property ( // RL14
        @(posedge clk_i)
        $rose(rst_n) |-> rx_gain_q == codec_ctl_pkg::RX_GAIN_RESET)
        else $error("receive gain not cleared by reset");
    xdcr_reset_a: assert property ( // RL18
        @(posedge clk_i)
        $rose(rst_n) |-> xdcr_q == codec_ctl_pkg::TRANSDUCER_RESET)
        else $error("transducer not cleared by reset");

    // Main scenarios: write each register, finish any read, read the transducer back
    gain_write_c: cover property (@(posedge clk_i) disable iff (!rst_n)
        wr_gain);
    xdcr_write_c: cover property (@(posedge clk_i) disable iff (!rst_n)
        wr_xdcr);
    read_c: cover property (@(posedge clk_i) disable iff (!rst_n)
        ad_oe_o ##1 !ad_oe_o);
    xdcr_read_c: cover property (@(posedge clk_i) disable iff (!rst_n)
        is_reg(addr_q, codec_ctl_pkg::TRANSDUCER_ADDR) ##1 ad_oe_o);
endmodule
`default_nettype wire

// file: testbench/bus_host.sv
// Host microcontroller model on the multiplexed address/data bus
`timescale 1ns/10ps
`default_nettype none
module bus_host (
    input wire logic clk_i,
    input wire logic [7:0] ad_i,
    input wire logic drv_i,
    output logic cs_n_o,
    output logic as_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [7:0] ad_o
);
    initial begin
        cs_n_o = 1'h1;
        as_o = 1'h0;
        rd_n_o = 1'h1;
        wr_n_o = 1'h1;
        ad_o = 8'hA5;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Address stays put well past the strobe edge so the synced copy is sure
    task automatic put_addr(input logic [7:0] a);
        ad_o = a;
        as_o = 1'h1;
        tick(4);
        as_o = 1'h0;
        tick(4);
    endtask
    task automatic write_raw(input logic [7:0] a, input logic [7:0] d);
        put_addr(a);
        ad_o = d;
        cs_n_o = 1'h0;
        wr_n_o = 1'h0;
        tick(4);
        wr_n_o = 1'h1;
        tick(4);
        cs_n_o = 1'h1;
        // Released bus shows the inverse so stale data never reads as valid
        ad_o = ~d;
        tick(2);
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        if (a == codec_ctl_pkg::TRANSDUCER_ADDR) begin
            d = d & codec_ctl_pkg::TRANSDUCER_USED_MASK;
        end
        write_raw(a, d);
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic drv);
        put_addr(a);
        ad_o = ~a;
        cs_n_o = 1'h0;
        rd_n_o = 1'h0;
        tick(6);
        d = ad_i;
        drv = drv_i;
        rd_n_o = 1'h1;
        tick(5);
        cs_n_o = 1'h1;
        tick(2);
    endtask
endmodule
`default_nettype wire

// file: testbench/codec_gain_transducer_control_bench.sv
// Self-checking bench for the codec gain and transducer register bank
`timescale 1ns/10ps
`default_nettype none
module codec_gain_transducer_control_bench;
    logic clk_i, reset_n_i, cs_n, as, rd_n, wr_n, dut_oe, drv;
    logic [7:0] host_ad, dut_ad, bus, rd, g, t;
    logic [7:0] gain_out;
    logic [5:0] trans_out;
    int n_errors = 0;
    int total_checks = 0;
    logic [23:0] rows [11] = '{24'h0B8080, 24'h0B7070, 24'h0B0F0F,
        24'h0B0101, 24'h0A2020, 24'h0A1010, 24'h0A0808, 24'h0A0404,
        24'h0A0202, 24'h0A0101, 24'h0A3F3F};
    assign bus = dut_oe ? dut_ad : host_ad;
    codec_gain_transducer_control codec_gain_transducer_control_inst (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n),
        .addr_strobe_i(as), .rd_n_i(rd_n), .wr_n_i(wr_n), .ad_i(bus),
        .ad_o(dut_ad), .ad_oe_o(dut_oe),
        .tx_highpass_enable_o(gain_out[7]),
        .rx_filter_gain_o(gain_out[6:4]),
        .rx_digital_gain_o(gain_out[3:0]),
        .dial_lowpass_enable_o(trans_out[5]),
        .sidetone_enable_o(trans_out[4]),
        .handset_mic_power_o(trans_out[3]),
        .speakerphone_mic_power_o(trans_out[2]),
        .speakerphone_speaker_power_o(trans_out[1]),
        .handset_speaker_power_o(trans_out[0]));
    bus_host bus_host_inst (.clk_i(clk_i), .ad_i(bus), .drv_i(dut_oe),
        .cs_n_o(cs_n), .as_o(as), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .ad_o(host_ad));
    // ------------------------------------------------------------
    // Compare and run-control tasks
    // ------------------------------------------------------------
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_pins(input logic [7:0] eg, input logic [7:0] et);
        total_checks++;
        if ({gain_out, 2'h0, trans_out} !== {eg, et}) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time,
                     {gain_out, 2'h0, trans_out}, {eg, et});
        end
    endtask
    task automatic rd_back(input logic [7:0] a, input logic [7:0] e);
        bus_host_inst.read_reg(a, rd, drv);
        check_byte({7'h00, drv}, 8'h01);
        check_byte(rd, e);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end
    // Whole run is well under 2000 clocks; this limit leaves a wide margin
    initial begin
        #100000;
        n_errors++;
        finish_test();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        reset_n_i = 1'h0;
        g = 8'h00;
        t = 8'h00;
        repeat (10) @(posedge clk_i);
        #1 reset_n_i = 1'h1;
        bus_host_inst.tick(6);
        check_pins(8'h00, 8'h00);
        rd_back(8'h0B, 8'h00);
        rd_back(8'h0A, 8'h00);
        $display("test reset values done");
        foreach (rows[i]) begin
            bus_host_inst.write_reg(rows[i][23:16], rows[i][15:8]);
            if (rows[i][23:16] == 8'h0B) g = rows[i][7:0];
            else t = rows[i][7:0];
            check_pins(g, t);
            rd_back(rows[i][23:16], rows[i][7:0]);
        end
        $display("test field table done");
        bus_host_inst.write_raw(8'h0C, 8'hFF);
        bus_host_inst.read_reg(8'h0C, rd, drv);
        check_byte({7'h00, drv}, 8'h00);
        check_pins(g, t);
        bus_host_inst.write_raw(8'h0A, 8'hFF);
        t = 8'h3F;
        rd_back(8'h0A, 8'h3F);
        $display("test unmapped and unused bits done");
        bus_host_inst.write_reg(8'h0B, 8'hC0);
        bus_host_inst.write_reg(8'h0A, 8'h06);
        check_pins(8'hC0, 8'h06);
        $display("test speakerphone setup done");
        bus_host_inst.write_reg(8'h0B, 8'h5A);
        bus_host_inst.write_reg(8'h0A, 8'h15);
        rd_back(8'h0B, 8'h5A);
        rd_back(8'h0A, 8'h15);
        check_pins(8'h5A, 8'h15);
        $display("test back to back done");
        reset_n_i = 1'h0;
        bus_host_inst.tick(3);
        check_pins(8'h00, 8'h00);
        reset_n_i = 1'h1;
        bus_host_inst.tick(6);
        rd_back(8'h0B, 8'h00);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule
`default_nettype wire
